// File: cpmg_top.v
// Privilege-mode guard: CPU mode tracking, mode-gated security registers
// and feature enables, behind an AXI4-Lite slave.
// Assumes CPU event inputs come from the core on aclk; attributes each bus
// write to the mode the CPU is in when the write is performed.
//
// How it works
// - segmentation registers writable in system mode only
// - security registers writable per-mode permission mask
// - system/firmware vector calls switch the mode
// - exception or interrupt entry enters system mode
// - return-from-interrupt restores the saved mode
// - extended call to entry address switches mode
// - permitted writes to mode bits switch mode
// - segment table lives in memory, unprotected here
// - partition layout is fixed, read only
// - features 0 to 3 can be temporarily disabled and re-enabled
// - permanent feature enables, locked by a write that sets bit 31
// - security registers and table base are software-managed
// - segment table base resets to zero
`include "cpmg_regs.vh"

module cpmg_top #(
    parameter [31:0] PARTITION_LAYOUT = 32'h0000_0000,
    parameter STACK_DEPTH = 4,
    parameter STACK_PW = 2
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`CPMG_AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [`CPMG_AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // CPU core events
    input wire cpu_exc_take,
    input wire cpu_reti,
    input wire cpu_call_valid,
    input wire cpu_call_ext,
    input wire [15:0] cpu_call_addr,
    // Protection state towards the core
    output wire [1:0] cpu_mode,
    output reg [31:0] seg_table_base,
    output reg [7:0] seg_ctl,
    output wire [5:0] feat_en
);
    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;

    reg aw_held_r;
    reg w_held_r;
    reg [`CPMG_AW-1:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg denied_r;
    reg [2:0] wp_mask;
    reg map_hit;
    reg [31:0] rd_word;
    reg rd_hit;
    reg csr_ok;
    reg [31:0] seg_base_nxt;

    wire [2:0] mode_oh;
    wire [3:0] temp_dis;
    wire [5:0] perm_en;
    wire perm_lock;
    wire do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
    wire [31:0] byte_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                             {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire mode_allowed = |(wp_mask & mode_oh);
    wire [1:0] new_mode = w_data_r[`CPMG_CSR_MODE_LSB+1:`CPMG_CSR_MODE_LSB];
    wire wr_csr = do_wr && aw_addr_r == `CPMG_OFF_CSR && mode_allowed && csr_ok;
    wire wr_seg_base = do_wr && aw_addr_r == `CPMG_OFF_SEG_BASE && mode_allowed;
    wire wr_seg_ctl = do_wr && aw_addr_r == `CPMG_OFF_SEG_CTL && mode_allowed
                      && w_strb_r[0];
    wire wr_temp = do_wr && aw_addr_r == `CPMG_OFF_FEAT_TEMP && mode_allowed
                   && w_strb_r[0];
    wire wr_perm = do_wr && aw_addr_r == `CPMG_OFF_FEAT_PERM && mode_allowed
                   && w_strb_r[0];
    wire wr_status = do_wr && aw_addr_r == `CPMG_OFF_STATUS && w_strb_r[0];
    wire wr_refused = do_wr && map_hit && aw_addr_r != `CPMG_OFF_STATUS
                      && !(wr_csr || wr_seg_base || wr_seg_ctl || wr_temp || wr_perm);

    // Write permission mask of the addressed register
    always @*
    begin
        wp_mask = 3'h0;
        map_hit = 1'b1;
        case (aw_addr_r)
            `CPMG_OFF_CSR: wp_mask = `CPMG_WP_CSR;
            `CPMG_OFF_SEG_BASE: wp_mask = `CPMG_WP_SEG;
            `CPMG_OFF_SEG_CTL: wp_mask = `CPMG_WP_SEG;
            `CPMG_OFF_FEAT_TEMP: wp_mask = `CPMG_WP_TEMP;
            `CPMG_OFF_FEAT_PERM: wp_mask = `CPMG_WP_PERM;
            `CPMG_OFF_STATUS: wp_mask = 3'h7;
            `CPMG_OFF_PARTITION: wp_mask = 3'h0;
            `CPMG_OFF_FEAT_EN: wp_mask = 3'h0;
            default: map_hit = 1'b0;
        endcase
    end

    // Mode bits: system may step down or stay, firmware may pick any valid mode
    always @*
    begin
        csr_ok = 1'b0;
        if (w_strb_r[0])
        begin
            if (mode_oh[2])
                csr_ok = new_mode != 2'h3;
            else if (mode_oh[1])
                csr_ok = new_mode == `CPMG_MODE_USER || new_mode == `CPMG_MODE_SYS;
        end
    end

    always @*
    begin
        seg_base_nxt = (seg_table_base & ~byte_mask) | (w_data_r & byte_mask);
    end

    // Read decode; an unmapped address answers SLVERR with zero data
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CPMG_OFF_CSR: rd_word = {30'h0000_0000, cpu_mode};
            `CPMG_OFF_SEG_BASE: rd_word = seg_table_base;
            `CPMG_OFF_SEG_CTL: rd_word = {24'h00_0000, seg_ctl};
            `CPMG_OFF_FEAT_TEMP: rd_word = {28'h000_0000, temp_dis};
            `CPMG_OFF_FEAT_PERM: rd_word = {perm_lock, 25'h000_0000, perm_en};
            `CPMG_OFF_STATUS: rd_word = {30'h0000_0000, perm_lock, denied_r};
            `CPMG_OFF_PARTITION: rd_word = PARTITION_LAYOUT;
            `CPMG_OFF_FEAT_EN: rd_word = {26'h000_0000, feat_en};
            default: rd_hit = 1'b0;
        endcase
    end

    // Write channel: address and data are taken in either order, then answered
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= {`CPMG_AW{1'b0}};
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // A refused write still answers OKAY; only a hole in the map errs
                s_axi_bresp <= map_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: data is returned the cycle after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Segmentation registers; the table entries themselves sit in plain
    // memory, so this block guards only the table base and control
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seg_table_base <= `CPMG_RST_SEG_BASE;
            seg_ctl <= `CPMG_RST_SEG_CTL;
        end
        else
        begin
            if (wr_seg_base)
                seg_table_base <= seg_base_nxt;
            if (wr_seg_ctl)
                seg_ctl <= w_data_r[7:0];
        end
    end

    // Sticky record of a refused write; a new refusal beats the clear
    always @(posedge aclk)
    begin
        if (!aresetn)
            denied_r <= 1'b0;
        else if (wr_refused)
            denied_r <= 1'b1;
        else if (wr_status && w_data_r[`CPMG_STAT_DENIED])
            denied_r <= 1'b0;
    end

    cpmg_mode_ctl #(
        .DEPTH(STACK_DEPTH),
        .PW(STACK_PW)
    ) u_mode (
        .aclk(aclk),
        .aresetn(aresetn),
        .exc_take(cpu_exc_take),
        .reti(cpu_reti),
        .call_valid(cpu_call_valid),
        .call_ext(cpu_call_ext),
        .call_addr(cpu_call_addr),
        .csr_wr(wr_csr),
        .csr_mode(new_mode),
        .mode_oh(mode_oh),
        .mode_code(cpu_mode)
    );

    cpmg_feature u_feat (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_temp(wr_temp),
        .wr_perm(wr_perm),
        .wdata(w_data_r),
        .temp_dis(temp_dis),
        .perm_en(perm_en),
        .perm_lock(perm_lock),
        .feat_en(feat_en)
    );
endmodule

// File: cpmg_regs.vh
// Offsets, field positions, reset values and mode codes of the privilege-mode guard.
// Assumes a 32-bit AXI4-Lite register bus decoding the low byte of the address.
`ifndef CPMG_REGS_VH
`define CPMG_REGS_VH

`define CPMG_AW 8

// Register byte offsets
`define CPMG_OFF_CSR 8'h00
`define CPMG_OFF_SEG_BASE 8'h04
`define CPMG_OFF_SEG_CTL 8'h08
`define CPMG_OFF_FEAT_TEMP 8'h0c
`define CPMG_OFF_FEAT_PERM 8'h10
`define CPMG_OFF_STATUS 8'h14
`define CPMG_OFF_PARTITION 8'h18
`define CPMG_OFF_FEAT_EN 8'h1c

// Reset values
`define CPMG_RST_SEG_BASE 32'h0000_0000
`define CPMG_RST_SEG_CTL 8'h00
`define CPMG_RST_TEMP 4'h0
`define CPMG_RST_PERM 6'h3f

// Mode codes as seen in the control/status register
`define CPMG_MODE_USER 2'h0
`define CPMG_MODE_SYS 2'h1
`define CPMG_MODE_FW 2'h2

// Write permission per register, one bit per mode: {firmware, system, user}
`define CPMG_WP_CSR 3'h6
`define CPMG_WP_SEG 3'h2
`define CPMG_WP_TEMP 3'h6
`define CPMG_WP_PERM 3'h4

// Field positions
`define CPMG_CSR_MODE_LSB 0
`define CPMG_STAT_DENIED 0
`define CPMG_STAT_LOCK 1
`define CPMG_PERM_LOCK 31

// Mode-changing call targets
`define CPMG_SYSTEM_CALL_VECTOR_ADDR 16'hff00
`define CPMG_FIRMWARE_CALL_VECTOR_ADDR 16'hff80
`define CPMG_USER_ENTRY_ADDR 16'hff40

`endif

// File: cpmg_mode_ctl.v
// Current CPU mode with a small stack of modes saved across exception entry.
// Assumes event inputs are single-cycle pulses from the CPU core on aclk.
`include "cpmg_regs.vh"

module cpmg_mode_ctl #(
    parameter DEPTH = 4,
    parameter PW = 2
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Mode events
    input wire exc_take,
    input wire reti,
    input wire call_valid,
    input wire call_ext,
    input wire [15:0] call_addr,
    input wire csr_wr,
    input wire [1:0] csr_mode,
    // Mode state
    output reg [2:0] mode_oh,
    output reg [1:0] mode_code
);
    localparam [2:0] ST_USER = 3'b001;
    localparam [2:0] ST_SYS = 3'b010;
    localparam [2:0] ST_FW = 3'b100;
    localparam [PW:0] DEPTH_C = DEPTH[PW:0];

    reg [2:0] stk [0:DEPTH-1];
    reg [PW:0] sp_r;
    reg [2:0] state_nxt;
    wire [PW:0] sp_m1 = sp_r - 1'b1;

    function [1:0] code_of;
        input [2:0] st;
        begin
            case (st)
                ST_USER: code_of = `CPMG_MODE_USER;
                ST_FW: code_of = `CPMG_MODE_FW;
                default: code_of = `CPMG_MODE_SYS;
            endcase
        end
    endfunction

    // Exception entry outranks return, call and register write in the same cycle
    always @*
    begin
        state_nxt = mode_oh;
        if (exc_take)
            state_nxt = ST_SYS;
        else if (reti)
            state_nxt = (sp_r != {(PW+1){1'b0}}) ? stk[sp_m1[PW-1:0]] : ST_SYS;
        else if (call_valid && call_addr == `CPMG_SYSTEM_CALL_VECTOR_ADDR)
            state_nxt = ST_SYS;
        else if (call_valid && call_addr == `CPMG_FIRMWARE_CALL_VECTOR_ADDR)
            state_nxt = ST_FW;
        else if (call_valid && call_ext && call_addr == `CPMG_USER_ENTRY_ADDR)
            state_nxt = ST_USER;
        else if (csr_wr)
        begin
            case (csr_mode)
                `CPMG_MODE_USER: state_nxt = ST_USER;
                `CPMG_MODE_FW: state_nxt = ST_FW;
                default: state_nxt = ST_SYS;
            endcase
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_oh <= ST_SYS;
            mode_code <= `CPMG_MODE_SYS;
            sp_r <= {(PW+1){1'b0}};
        end
        else
        begin
            mode_oh <= state_nxt;
            mode_code <= code_of(state_nxt);
            // A nesting deeper than the stack loses the innermost return mode
            if (exc_take && sp_r < DEPTH_C)
            begin
                stk[sp_r[PW-1:0]] <= mode_oh;
                sp_r <= sp_r + 1'b1;
            end
            else if (!exc_take && reti && sp_r != {(PW+1){1'b0}})
                sp_r <= sp_m1;
        end
    end
endmodule

// File: cpmg_feature.v
// Temporary and permanent feature enables for memory-size limits and coprocessors.
// Assumes write strobes arrive already checked for mode permission.
`include "cpmg_regs.vh"

module cpmg_feature (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write strobes and data
    input wire wr_temp,
    input wire wr_perm,
    input wire [31:0] wdata,
    // State
    output reg [3:0] temp_dis,
    output reg [5:0] perm_en,
    output reg perm_lock,
    output reg [5:0] feat_en
);
    // Bits: 0 nvm size limit, 1 coprocessor_ram size limit, 2 block cipher,
    // 3 public key, 4 contactless software, 5 its nvm allocation.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            temp_dis <= `CPMG_RST_TEMP;
            perm_en <= `CPMG_RST_PERM;
            perm_lock <= 1'b0;
            feat_en <= `CPMG_RST_PERM;
        end
        else
        begin
            if (wr_temp)
                temp_dis <= wdata[3:0];
            // One-shot: once locked only a reset reopens it
            if (wr_perm && !perm_lock)
            begin
                perm_en <= wdata[5:0];
                perm_lock <= wdata[`CPMG_PERM_LOCK];
            end
            feat_en <= perm_en & ~{2'b00, temp_dis};
        end
    end
endmodule

// File: cpmg_top_sva.sv
// Checker for the privilege-mode guard: mode events, gated writes, read path.
// Assumes it is bound to cpmg_top and sees only its ports.
`include "cpmg_regs.vh"

module cpmg_top_sva #(
    parameter [31:0] PARTITION_LAYOUT = 32'h0000_0000
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`CPMG_AW-1:0] s_axi_araddr,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_bvalid,
    // CPU events and state
    input wire cpu_exc_take,
    input wire cpu_reti,
    input wire cpu_call_valid,
    input wire cpu_call_ext,
    input wire [15:0] cpu_call_addr,
    input wire [1:0] cpu_mode,
    input wire [31:0] seg_table_base,
    input wire [7:0] seg_ctl,
    input wire [5:0] feat_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Calls lose to exception entry and return in the same cycle
    wire call_only = cpu_call_valid && !cpu_exc_take && !cpu_reti;

    property p_exc;
        cpu_exc_take |=> cpu_mode == `CPMG_MODE_SYS;
    endproperty
    a_exc: assert property (p_exc)
        else $error("no system mode after exception entry");
    property p_system_call_vector;
        call_only && cpu_call_addr == `CPMG_SYSTEM_CALL_VECTOR_ADDR |=> cpu_mode == `CPMG_MODE_SYS;
    endproperty
    a_system_call_vector: assert property (p_system_call_vector)
        else $error("system call vector gave wrong mode");
    property p_firmware_call_vector;
        call_only && cpu_call_addr == `CPMG_FIRMWARE_CALL_VECTOR_ADDR |=> cpu_mode == `CPMG_MODE_FW;
    endproperty
    a_firmware_call_vector: assert property (p_firmware_call_vector)
        else $error("firmware vector gave wrong mode");
    property p_extended_call_instruction;
        call_only && cpu_call_ext && cpu_call_addr == `CPMG_USER_ENTRY_ADDR
            |=> cpu_mode == `CPMG_MODE_USER;
    endproperty
    a_extended_call_instruction: assert property (p_extended_call_instruction)
        else $error("extended call to entry gave wrong mode");
    property p_reti;
        cpu_exc_take ##1 (cpu_reti && !cpu_exc_take) |=> cpu_mode == $past(cpu_mode, 2);
    endproperty
    a_reti: assert property (p_reti)
        else $error("return did not restore saved mode");
    property p_cause;
        !$stable(cpu_mode) |-> $past(cpu_exc_take) || $past(cpu_reti)
            || $past(cpu_call_valid) || $rose(s_axi_bvalid);
    endproperty
    a_cause: assert property (p_cause)
        else $error("mode changed without a cause");
    property p_seg;
        !$stable(seg_table_base) || !$stable(seg_ctl)
            |-> $rose(s_axi_bvalid) && $past(cpu_mode) == `CPMG_MODE_SYS;
    endproperty
    a_seg: assert property (p_seg)
        else $error("segmentation changed outside system mode");
    property p_feat;
        !$stable(feat_en) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
            && $past(cpu_mode, 2) != `CPMG_MODE_USER;
    endproperty
    a_feat: assert property (p_feat)
        else $error("feature enables changed without a permitted write");
    property p_seg_rst;
        disable iff (1'b0) !aresetn |=> seg_table_base == 32'h0 && seg_ctl == 8'h0;
    endproperty
    a_seg_rst: assert property (p_seg_rst)
        else $error("segment table base not cleared by reset");
    property p_part;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `CPMG_OFF_PARTITION
            |=> s_axi_rvalid && s_axi_rdata == PARTITION_LAYOUT;
    endproperty
    a_part: assert property (p_part)
        else $error("partition layout read wrong");
endmodule

// File: cpmg_top_tb.sv
// Self-checking bench for the privilege-mode guard: bus tasks, event table, random mix.
// Assumes the checker file is compiled first; a small mode model gives expectations.
`include "cpmg_regs.vh"

module cpmg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] PART = 32'h0000_5a3c;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [`CPMG_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, seg_table_base, rd, seed, v, exp_seg;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, cpu_mode, exp_mode, rs;
    logic cpu_exc_take, cpu_reti, cpu_call_valid, cpu_call_ext;
    logic [15:0] cpu_call_addr;
    logic [7:0] seg_ctl;
    logic [5:0] feat_en, ec;
    logic [1:0] stk[$];
    logic [15:0] tgt [4] = '{16'h0, `CPMG_SYSTEM_CALL_VECTOR_ADDR, `CPMG_FIRMWARE_CALL_VECTOR_ADDR, `CPMG_USER_ENTRY_ADDR};
    logic [5:0] evt [10] = '{6'h20, 6'h0a, 6'h20, 6'h10, 6'h10, 6'h10, 6'h0b, 6'h0f, 6'h09,
        6'h30};
    logic [5:0] csr_t [4] = '{6'h10, 6'h04, 6'h2e, 6'h25};
    logic [31:0] rst_val [8] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h3f, 32'h0, PART, 32'h3f};
    int err_total = 0;
    int comparisons = 0;

    cpmg_top #(.PARTITION_LAYOUT(PART)) cpmg_top_inst (.aclk, .aresetn, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpu_exc_take, .cpu_reti, .cpu_call_valid,
        .cpu_call_ext, .cpu_call_addr, .cpu_mode, .seg_table_base, .seg_ctl, .feat_en);

    initial
    begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [1:0] call_mode(input logic [15:0] a, input logic e,
        input logic [1:0] m);
        if (a == `CPMG_SYSTEM_CALL_VECTOR_ADDR) return `CPMG_MODE_SYS;
        if (a == `CPMG_FIRMWARE_CALL_VECTOR_ADDR) return `CPMG_MODE_FW;
        if (a == `CPMG_USER_ENTRY_ADDR && e) return `CPMG_MODE_USER;
        return m;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do
        begin
            @(posedge aclk);
            ad = ad | (s_axi_awvalid & s_axi_awready);
            wd = wd | (s_axi_wvalid & s_axi_wready);
            if (ad) s_axi_awvalid <= 0;
            if (wd) s_axi_wvalid <= 0;
        end while (!(ad && wd));
        s_axi_bready <= 1;
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask

    // Pulses one cycle, then idles one so the new mode is sampled settled
    task automatic ev(input logic x, t, c, e, input logic [15:0] a);
        cpu_exc_take <= x;
        cpu_reti <= t;
        cpu_call_valid <= c;
        cpu_call_ext <= e;
        cpu_call_addr <= a;
        @(posedge aclk);
        if (x)
        begin
            if (stk.size() < 4) stk.push_back(exp_mode);
            exp_mode = `CPMG_MODE_SYS;
        end
        else if (t)
            exp_mode = stk.size() ? stk.pop_back() : `CPMG_MODE_SYS;
        else if (c)
            exp_mode = call_mode(a, e, exp_mode);
        {cpu_exc_take, cpu_reti, cpu_call_valid} <= 3'h0;
        @(posedge aclk);
        chk(cpu_mode, exp_mode);
    endtask

    task automatic go(input logic [1:0] m);
        ev(0, 0, 1, 1, m == 2'h0 ? tgt[3] : (m == 2'h1 ? tgt[1] : tgt[2]));
    endtask

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {cpu_exc_take, cpu_reti, cpu_call_valid, cpu_call_ext, cpu_call_addr} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hf;
        seed = 32'h0000_0022;
        exp_mode = `CPMG_MODE_SYS;
        exp_seg = 32'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        for (int i = 0; i < 8; i++)
        begin
            axr(8'(i * 4), rd, rs);
            chk(rd, rst_val[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 50; i++)
        begin
            seed = lfsr(seed);
            ec = i < 10 ? evt[i] : seed[5:0];
            // Deeper nesting than the saved-mode stack is not modelled
            if (stk.size() == 4) ec[5] = 0;
            ev(ec[5], ec[4], ec[3], ec[2], ec[1:0] == 2'h0 ? seed[31:16] : tgt[ec[1:0]]);
        end
        // Back-to-back entry and return: the pop must see the mode pushed one cycle earlier
        ev(0, 1, 0, 0, 16'h0);
        cpu_exc_take <= 1;
        @(posedge aclk);
        {cpu_exc_take, cpu_reti} <= 2'b01;
        @(posedge aclk);
        cpu_reti <= 0;
        @(posedge aclk);
        chk(cpu_mode, exp_mode);
        $display("test mode events done");
        for (int m = 0; m < 3; m++)
        begin
            go(2'(m));
            seed = lfsr(seed);
            axw(`CPMG_OFF_SEG_BASE, seed, rs);
            if (m == 1) exp_seg = seed;
            chk(seg_table_base, exp_seg);
            axw(`CPMG_OFF_SEG_CTL, seed, rs);
            chk(seg_ctl, {24'h0, exp_seg[7:0]});
            axr(`CPMG_OFF_STATUS, rd, rs);
            chk(rd[0], m != 1);
            axw(`CPMG_OFF_STATUS, 32'h1, rs);
        end
        foreach (csr_t[i])
        begin
            go(csr_t[i][5:4]);
            axw(`CPMG_OFF_CSR, {30'h0, csr_t[i][3:2]}, rs);
            exp_mode = csr_t[i][1:0];
            chk(cpu_mode, exp_mode);
        end
        axw(`CPMG_OFF_STATUS, 32'h1, rs);
        $display("test mode permissions done");
        go(`CPMG_MODE_SYS);
        seed = lfsr(seed);
        axw(`CPMG_OFF_FEAT_TEMP, seed, rs);
        chk(feat_en, 6'h3f & ~{2'h0, seed[3:0]});
        axw(`CPMG_OFF_FEAT_PERM, 32'h0, rs);
        chk(feat_en, 6'h3f & ~{2'h0, seed[3:0]});
        axw(`CPMG_OFF_FEAT_TEMP, 32'h0, rs);
        chk(feat_en, 6'h3f);
        go(`CPMG_MODE_FW);
        v = {1'b1, 25'h0, seed[9:4]};
        axw(`CPMG_OFF_FEAT_PERM, v, rs);
        chk(feat_en, seed[9:4]);
        axw(`CPMG_OFF_FEAT_PERM, 32'h3f, rs);
        axr(`CPMG_OFF_FEAT_PERM, rd, rs);
        chk(rd, v);
        axr(`CPMG_OFF_STATUS, rd, rs);
        chk(rd[1:0], 2'h3);
        $display("test features done");
        axw(8'h20, seed, rs);
        chk(rs, 2'h2);
        axr(8'h20, rd, rs);
        chk(rd, 32'h0);
        chk(rs, 2'h2);
        axw(`CPMG_OFF_PARTITION, ~PART, rs);
        axr(`CPMG_OFF_PARTITION, rd, rs);
        chk(rd, PART);
        $display("test address map done");
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk(cpu_mode, `CPMG_MODE_SYS);
        chk(seg_table_base, 32'h0);
        chk(feat_en, 6'h3f);
        $display("test second reset done");
        give_verdict;
    end

    // Whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge aclk);
        err_total++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict;
    end
endmodule

bind cpmg_top cpmg_top_sva #(.PARTITION_LAYOUT(PARTITION_LAYOUT)) cpmg_top_sva_inst (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rdata, .s_axi_bvalid, .cpu_exc_take, .cpu_reti, .cpu_call_valid, .cpu_call_ext,
    .cpu_call_addr, .cpu_mode, .seg_table_base, .seg_ctl, .feat_en);
